// file: verilog/pkm_port_mux.sv
module pkm_port_mux
   import pkm_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_irq,
   input wire logic [W-1:0] i_port_k_pin,
   input wire logic [W-1:0] i_port_k_out,
   input wire logic [W-1:0] i_port_k_dir,
   input wire logic [W-1:0] i_port_k_pullup,
   input wire logic [W-1:0] i_port_k_in_disable,
   input wire logic [W-1:0] i_port_l_pin,
   input wire logic [W-1:0] i_port_l_out,
   input wire logic [W-1:0] i_port_l_dir,
   input wire logic [W-1:0] i_port_l_pullup,
   input wire logic [W-1:0] i_port_l_in_disable,
   input wire logic [2:0] i_timer5_compare_en,
   input wire logic [2:0] i_timer5_compare_out,
   input wire logic [3:0] i_converter_channel_sel,
   output logic [W-1:0] o_k_pullup_override_enable,
   output logic [W-1:0] o_k_pullup_override_value,
   output logic [W-1:0] o_k_direction_override_enable,
   output logic [W-1:0] o_k_direction_override_value,
   output logic [W-1:0] o_k_out_value_override_enable,
   output logic [W-1:0] o_k_out_value_override_value,
   output logic [W-1:0] o_k_input_enable_override_enable,
   output logic [W-1:0] o_k_input_enable_override_value,
   output logic [W-1:0] o_k_pad_out,
   output logic [W-1:0] o_k_pad_oe,
   output logic [W-1:0] o_k_pad_pullup,
   output logic [W-1:0] o_k_pad_in_en,
   output logic [W-1:0] o_l_pullup_override_enable,
   output logic [W-1:0] o_l_pullup_override_value,
   output logic [W-1:0] o_l_direction_override_enable,
   output logic [W-1:0] o_l_direction_override_value,
   output logic [W-1:0] o_l_out_value_override_enable,
   output logic [W-1:0] o_l_out_value_override_value,
   output logic [W-1:0] o_l_input_enable_override_enable,
   output logic [W-1:0] o_l_input_enable_override_value,
   output logic [W-1:0] o_l_pad_out,
   output logic [W-1:0] o_l_pad_oe,
   output logic [W-1:0] o_l_pad_pullup,
   output logic [W-1:0] o_l_pad_in_en,
   output logic [W-1:0] o_pin_change_source_high_group,
   output logic [W-1:0] o_converter_channel_15_to_8,
   output logic o_timer5_clock_pin,
   output logic o_timer5_capture_trigger,
   output logic o_timer4_capture_trigger
);
   logic [W-1:0] pc_mask_q;
   logic pin_change_group_two_enable_q;
   logic [PKM_IRQ_W-1:0] irq_status_q;
   logic [PKM_IRQ_W-1:0] irq_enable_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [W-1:0] k_s1_q;
   logic [W-1:0] k_s2_q;
   logic [W-1:0] k_prev_q;
   logic [W-1:0] l_s1_q;
   logic [W-1:0] l_s2_q;
   logic [W-1:0] l_prev_q;
   logic wr_hit;
   logic [W-1:0] k_in_en_ovr;
   logic [W-1:0] l_out_ovr_en;
   logic [W-1:0] l_out_ovr_val;
   logic [PKM_IRQ_W-1:0] irq_event;
   logic [PKM_IRQ_W-1:0] irq_clear;
   logic [15:0] wr_mask;
   logic [31:0] rd_mux;

   pkm_ovr_if #(.W(W)) k_ovr ();
   pkm_ovr_if #(.W(W)) l_ovr ();

   // Bus handshake: one wait cycle, then the access completes
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         wait_q <= 1'b1;
      end else if ((i_avs_read || i_avs_write) && wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   assign wr_hit = i_avs_write && !wait_q;
   assign wr_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (i_avs_address)
         PKM_OFS_PC_MASK: rd_mux[W-1:0] = pc_mask_q;
         PKM_OFS_PC_CTRL: rd_mux[PKM_GROUP_TWO_EN_BIT] = pin_change_group_two_enable_q;
         PKM_OFS_K_SENSE: rd_mux[W-1:0] = k_s2_q;
         PKM_OFS_L_SENSE: rd_mux[W-1:0] = l_s2_q;
         PKM_OFS_IRQ_STATUS: rd_mux[PKM_IRQ_W-1:0] = irq_status_q;
         PKM_OFS_IRQ_ENABLE: rd_mux[PKM_IRQ_W-1:0] = irq_enable_q;
         // Clear register and unmapped addresses read as zero
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data captured in the wait cycle, stands when waitrequest drops
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         rdata_q <= PKM_RST_RDATA;
      end else if (i_avs_read && wait_q) begin
         rdata_q <= rd_mux;
      end
   end

   // Control registers
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         pc_mask_q <= PKM_RST_PC_MASK;
         pin_change_group_two_enable_q <= 1'b0;
         irq_enable_q <= PKM_RST_IRQ;
      end else if (wr_hit) begin
         if (i_avs_address == PKM_OFS_PC_MASK && i_avs_byteenable[0]) begin
            pc_mask_q <= i_avs_writedata[W-1:0];
         end
         if (i_avs_address == PKM_OFS_PC_CTRL && i_avs_byteenable[0]) begin
            pin_change_group_two_enable_q <= i_avs_writedata[PKM_GROUP_TWO_EN_BIT];
         end
         if (i_avs_address == PKM_OFS_IRQ_ENABLE) begin
            irq_enable_q <= (irq_enable_q & ~wr_mask[PKM_IRQ_W-1:0])
               | (i_avs_writedata[PKM_IRQ_W-1:0] & wr_mask[PKM_IRQ_W-1:0]);
         end
      end
   end

   // Two-stage synchronisers; first stage feeds only the second
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         k_s1_q <= PKM_RST_SYNC;
         k_s2_q <= PKM_RST_SYNC;
         l_s1_q <= PKM_RST_SYNC;
         l_s2_q <= PKM_RST_SYNC;
      end else begin
         k_s1_q <= i_port_k_pin;
         k_s2_q <= k_s1_q;
         l_s1_q <= i_port_l_pin;
         l_s2_q <= l_s1_q;
      end
   end

   // Previous synchronised value for change detection
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         k_prev_q <= PKM_RST_SYNC;
         l_prev_q <= PKM_RST_SYNC;
      end else begin
         k_prev_q <= k_s2_q;
         l_prev_q <= l_s2_q;
      end
   end

   // Input buffer forced on only for armed pin-change pins
   assign k_in_en_ovr = pc_mask_q & {W{pin_change_group_two_enable_q}};

   // Port L value overrides: compare A/B/C on bits 3/4/5, PWM included
   always_comb begin
      l_out_ovr_en = '0;
      l_out_ovr_val = '0;
      for (int c = 0; c < 3; c++) begin
         l_out_ovr_en[PKM_L_CMP_A + c] = i_timer5_compare_en[c];
         l_out_ovr_val[PKM_L_CMP_A + c] = i_timer5_compare_out[c];
      end
   end

   // Events: armed pin changes and rising capture edges
   always_comb begin
      irq_event = '0;
      irq_event[W-1:0] = (k_s2_q ^ k_prev_q) & k_in_en_ovr;
      irq_event[PKM_IRQ_T5_CAPTURE_BIT] =
         l_s2_q[PKM_L_T5_CAPTURE] & ~l_prev_q[PKM_L_T5_CAPTURE];
      irq_event[PKM_IRQ_T4_CAPTURE_BIT] =
         l_s2_q[PKM_L_T4_CAPTURE] & ~l_prev_q[PKM_L_T4_CAPTURE];
   end

   assign irq_clear = (wr_hit && i_avs_address == PKM_OFS_IRQ_CLEAR)
      ? (i_avs_writedata[PKM_IRQ_W-1:0] & wr_mask[PKM_IRQ_W-1:0]) : '0;

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         irq_status_q <= PKM_RST_IRQ;
      end else begin
         irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status_q & irq_enable_q);
      end
   end

   // Peripheral taps, all from synchronised pins
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_pin_change_source_high_group <= '0;
         o_timer5_clock_pin <= 1'b0;
         o_timer5_capture_trigger <= 1'b0;
         o_timer4_capture_trigger <= 1'b0;
      end else begin
         o_pin_change_source_high_group <= k_s2_q;
         o_timer5_clock_pin <= l_s2_q[PKM_L_T5_CLOCK];
         o_timer5_capture_trigger <= l_s2_q[PKM_L_T5_CAPTURE];
         o_timer4_capture_trigger <= l_s2_q[PKM_L_T4_CAPTURE];
      end
   end

   // Analog switch closes for the selected channel only
   for (genvar b = 0; b < W; b++) begin : g_analog
      always_ff @(posedge i_mclk) begin
         if (i_sys_rst) begin
            o_converter_channel_15_to_8[b] <= 1'b0;
         end else begin
            o_converter_channel_15_to_8[b] <=
               (i_converter_channel_sel == PKM_CONV_CH_BASE + 4'(b));
         end
      end
   end

   // Port K: only the input enable is ever overridden
   pkm_pin_ovr #(.W(W)) u_k_ovr (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_out_ovr_en('0),
      .i_out_ovr_val('0),
      .i_in_en_ovr_en(k_in_en_ovr),
      .i_port_out(i_port_k_out),
      .i_port_dir(i_port_k_dir),
      .i_port_pullup(i_port_k_pullup),
      .i_port_in_disable(i_port_k_in_disable),
      .o_ovr(k_ovr.drv)
   );

   // Port L: bits 7, 6, 2, 1, 0 carry no override at all
   pkm_pin_ovr #(.W(W)) u_l_ovr (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_out_ovr_en(l_out_ovr_en),
      .i_out_ovr_val(l_out_ovr_val),
      .i_in_en_ovr_en('0),
      .i_port_out(i_port_l_out),
      .i_port_dir(i_port_l_dir),
      .i_port_pullup(i_port_l_pullup),
      .i_port_in_disable(i_port_l_in_disable),
      .o_ovr(l_ovr.drv)
   );

   assign o_avs_readdata = rdata_q;
   assign o_avs_waitrequest = wait_q;

   // Flop outputs of the override stage
   assign o_k_pullup_override_enable = k_ovr.pullup_override_enable;
   assign o_k_pullup_override_value = k_ovr.pullup_override_value;
   assign o_k_direction_override_enable = k_ovr.direction_override_enable;
   assign o_k_direction_override_value = k_ovr.direction_override_value;
   assign o_k_out_value_override_enable = k_ovr.out_value_override_enable;
   assign o_k_out_value_override_value = k_ovr.out_value_override_value;
   assign o_k_input_enable_override_enable = k_ovr.input_enable_override_enable;
   assign o_k_input_enable_override_value = k_ovr.input_enable_override_value;
   assign o_k_pad_out = k_ovr.pad_out;
   assign o_k_pad_oe = k_ovr.pad_oe;
   assign o_k_pad_pullup = k_ovr.pad_pullup;
   assign o_k_pad_in_en = k_ovr.pad_in_en;
   assign o_l_pullup_override_enable = l_ovr.pullup_override_enable;
   assign o_l_pullup_override_value = l_ovr.pullup_override_value;
   assign o_l_direction_override_enable = l_ovr.direction_override_enable;
   assign o_l_direction_override_value = l_ovr.direction_override_value;
   assign o_l_out_value_override_enable = l_ovr.out_value_override_enable;
   assign o_l_out_value_override_value = l_ovr.out_value_override_value;
   assign o_l_input_enable_override_enable = l_ovr.input_enable_override_enable;
   assign o_l_input_enable_override_value = l_ovr.input_enable_override_value;
   assign o_l_pad_out = l_ovr.pad_out;
   assign o_l_pad_oe = l_ovr.pad_oe;
   assign o_l_pad_pullup = l_ovr.pad_pullup;
   assign o_l_pad_in_en = l_ovr.pad_in_en;
endmodule : pkm_port_mux

// file: common/pkm_pkg.sv
package pkm_pkg;
   // Register byte offsets
   localparam logic [4:0] PKM_OFS_PC_MASK = 5'h00;
   localparam logic [4:0] PKM_OFS_PC_CTRL = 5'h04;
   localparam logic [4:0] PKM_OFS_K_SENSE = 5'h08;
   localparam logic [4:0] PKM_OFS_L_SENSE = 5'h0c;
   localparam logic [4:0] PKM_OFS_IRQ_STATUS = 5'h10;
   localparam logic [4:0] PKM_OFS_IRQ_CLEAR = 5'h14;
   localparam logic [4:0] PKM_OFS_IRQ_ENABLE = 5'h18;

   // Field positions
   localparam int PKM_GROUP_TWO_EN_BIT = 0;
   localparam int PKM_IRQ_T5_CAPTURE_BIT = 8;
   localparam int PKM_IRQ_T4_CAPTURE_BIT = 9;
   localparam int PKM_IRQ_W = 10;

   // Port L pin positions
   localparam int PKM_L_T4_CAPTURE = 0;
   localparam int PKM_L_T5_CAPTURE = 1;
   localparam int PKM_L_T5_CLOCK = 2;
   localparam int PKM_L_CMP_A = 3;

   // Converter channel fed by port K bit 0
   localparam logic [3:0] PKM_CONV_CH_BASE = 4'h8;

   // Values after reset
   localparam logic [7:0] PKM_RST_PC_MASK = 8'h00;
   localparam logic [PKM_IRQ_W-1:0] PKM_RST_IRQ = 10'h000;
   localparam logic [7:0] PKM_RST_SYNC = 8'h00;
   localparam logic [31:0] PKM_RST_RDATA = 32'h0000_0000;
endpackage : pkm_pkg

// file: common/pkm_ovr_if.sv
interface pkm_ovr_if #(
   parameter int W = 8
);
   logic [W-1:0] pullup_override_enable;
   logic [W-1:0] pullup_override_value;
   logic [W-1:0] direction_override_enable;
   logic [W-1:0] direction_override_value;
   logic [W-1:0] out_value_override_enable;
   logic [W-1:0] out_value_override_value;
   logic [W-1:0] input_enable_override_enable;
   logic [W-1:0] input_enable_override_value;
   logic [W-1:0] pad_out;
   logic [W-1:0] pad_oe;
   logic [W-1:0] pad_pullup;
   logic [W-1:0] pad_in_en;

   modport drv (
      output pullup_override_enable,
      output pullup_override_value,
      output direction_override_enable,
      output direction_override_value,
      output out_value_override_enable,
      output out_value_override_value,
      output input_enable_override_enable,
      output input_enable_override_value,
      output pad_out,
      output pad_oe,
      output pad_pullup,
      output pad_in_en
   );
   modport use_side (
      input pullup_override_enable,
      input pullup_override_value,
      input direction_override_enable,
      input direction_override_value,
      input out_value_override_enable,
      input out_value_override_value,
      input input_enable_override_enable,
      input input_enable_override_value,
      input pad_out,
      input pad_oe,
      input pad_pullup,
      input pad_in_en
   );
endinterface : pkm_ovr_if

// file: verilog/pkm_pin_ovr.sv
module pkm_pin_ovr
   import pkm_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [W-1:0] i_out_ovr_en,
   input wire logic [W-1:0] i_out_ovr_val,
   input wire logic [W-1:0] i_in_en_ovr_en,
   input wire logic [W-1:0] i_port_out,
   input wire logic [W-1:0] i_port_dir,
   input wire logic [W-1:0] i_port_pullup,
   input wire logic [W-1:0] i_port_in_disable,
   pkm_ovr_if.drv o_ovr
);
   // Neither port ever takes over pull-up or direction
   always_ff @(posedge i_mclk) begin
      o_ovr.pullup_override_enable <= '0;
      o_ovr.pullup_override_value <= '0;
      o_ovr.direction_override_enable <= '0;
      o_ovr.direction_override_value <= '0;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_ovr.out_value_override_enable <= '0;
         o_ovr.out_value_override_value <= '0;
         o_ovr.input_enable_override_enable <= '0;
         o_ovr.input_enable_override_value <= '0;
      end else begin
         o_ovr.out_value_override_enable <= i_out_ovr_en;
         o_ovr.out_value_override_value <= i_out_ovr_val & i_out_ovr_en;
         o_ovr.input_enable_override_enable <= i_in_en_ovr_en;
         o_ovr.input_enable_override_value <= i_in_en_ovr_en;
      end
   end

   // Resolved pad controls; same cycle as the override bundle
   for (genvar b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge i_mclk) begin
         if (i_sys_rst) begin
            o_ovr.pad_out[b] <= 1'b0;
            o_ovr.pad_oe[b] <= 1'b0;
            o_ovr.pad_pullup[b] <= 1'b0;
            o_ovr.pad_in_en[b] <= 1'b0;
         end else begin
            o_ovr.pad_out[b] <= i_out_ovr_en[b] ? i_out_ovr_val[b] : i_port_out[b];
            o_ovr.pad_oe[b] <= i_port_dir[b];
            // Pull-up only acts on an input pin
            o_ovr.pad_pullup[b] <= i_port_pullup[b] & ~i_port_dir[b];
            o_ovr.pad_in_en[b] <= i_in_en_ovr_en[b] | ~i_port_in_disable[b];
         end
      end
   end
endmodule : pkm_pin_ovr

// file: tb/pkm_port_mux_chk.sv
module pkm_port_mux_chk
   import pkm_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic [W-1:0] i_port_k_pin,
   input wire logic [W-1:0] i_port_l_pin,
   input wire logic [2:0] i_timer5_compare_en,
   input wire logic [2:0] i_timer5_compare_out,
   input wire logic [3:0] i_converter_channel_sel,
   input wire logic [W-1:0] o_k_pullup_override_enable,
   input wire logic [W-1:0] o_k_pullup_override_value,
   input wire logic [W-1:0] o_k_direction_override_enable,
   input wire logic [W-1:0] o_k_direction_override_value,
   input wire logic [W-1:0] o_k_out_value_override_value,
   input wire logic [W-1:0] o_l_pullup_override_value,
   input wire logic [W-1:0] o_l_direction_override_value,
   input wire logic [W-1:0] o_l_input_enable_override_value,
   input wire logic [W-1:0] o_k_out_value_override_enable,
   input wire logic [W-1:0] o_k_input_enable_override_enable,
   input wire logic [W-1:0] o_k_input_enable_override_value,
   input wire logic [W-1:0] o_l_pullup_override_enable,
   input wire logic [W-1:0] o_l_direction_override_enable,
   input wire logic [W-1:0] o_l_out_value_override_enable,
   input wire logic [W-1:0] o_l_out_value_override_value,
   input wire logic [W-1:0] o_l_input_enable_override_enable,
   input wire logic [W-1:0] o_pin_change_source_high_group,
   input wire logic [W-1:0] o_converter_channel_15_to_8,
   input wire logic o_timer5_clock_pin,
   input wire logic o_timer5_capture_trigger,
   input wire logic o_timer4_capture_trigger
);
   // Edges since reset; $past must not reach into reset
   logic [1:0] run_q;
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         run_q <= 2'h0;
      end else if (run_q != 2'h3) begin
         run_q <= run_q + 2'h1;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   sequence s_ack;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> s_ack) else $error("bus answer not after one cycle");
   a_k_fixed_zero: assert property ((o_k_pullup_override_enable
      | o_k_pullup_override_value | o_k_direction_override_enable
      | o_k_direction_override_value | o_k_out_value_override_enable
      | o_k_out_value_override_value) == '0)
      else $error("port K override not zero");
   a_k_ie_pair: assert property (o_k_input_enable_override_value
      == o_k_input_enable_override_enable) else $error("port K input override value");
   a_l_fixed_zero: assert property ((o_l_pullup_override_enable
      | o_l_pullup_override_value | o_l_direction_override_enable
      | o_l_direction_override_value | o_l_input_enable_override_enable
      | o_l_input_enable_override_value) == '0)
      else $error("port L override not zero");
   a_cmp_enable: assert property (run_q != 2'h0 |-> o_l_out_value_override_enable
      == {2'h0, $past(i_timer5_compare_en), 3'h0}) else $error("compare enable path");
   a_cmp_value: assert property (run_q != 2'h0 |-> o_l_out_value_override_value
      == {2'h0, $past(i_timer5_compare_en) & $past(i_timer5_compare_out), 3'h0})
      else $error("compare value path");
   a_pc_tap: assert property (run_q == 2'h3 |-> o_pin_change_source_high_group
      == $past(i_port_k_pin, 3)) else $error("pin change tap");
   a_timer_taps: assert property (run_q == 2'h3 |-> {5'h0, o_timer5_clock_pin,
      o_timer5_capture_trigger, o_timer4_capture_trigger} == ($past(i_port_l_pin, 3) & 8'h07))
      else $error("timer input taps");
   a_conv_switch: assert property (run_q != 2'h0 |-> o_converter_channel_15_to_8
      == ($past(i_converter_channel_sel) >= 4'h8 ?
      8'h01 << ($past(i_converter_channel_sel) - 4'h8) : 8'h00)) else $error("converter switch");
endmodule : pkm_port_mux_chk

bind pkm_port_mux pkm_port_mux_chk #(.W(W)) i_pkm_port_mux_chk (
   .i_mclk, .i_sys_rst, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_port_k_pin,
   .i_port_l_pin, .i_timer5_compare_en, .i_timer5_compare_out, .i_converter_channel_sel,
   .o_k_pullup_override_enable, .o_k_direction_override_enable, .o_k_out_value_override_enable,
   .o_k_pullup_override_value, .o_k_direction_override_value, .o_k_out_value_override_value,
   .o_l_pullup_override_value, .o_l_direction_override_value, .o_l_input_enable_override_value,
   .o_k_input_enable_override_enable, .o_k_input_enable_override_value,
   .o_l_pullup_override_enable, .o_l_direction_override_enable, .o_l_out_value_override_enable,
   .o_l_out_value_override_value, .o_l_input_enable_override_enable,
   .o_pin_change_source_high_group, .o_converter_channel_15_to_8, .o_timer5_clock_pin,
   .o_timer5_capture_trigger, .o_timer4_capture_trigger
);

// file: tb/pkm_far_model.sv
module pkm_far_model (
   input wire logic i_mclk,
   input wire logic [7:0] i_k_lvl,
   input wire logic [7:0] i_l_lvl,
   input wire logic [7:0] i_l_dir,
   input wire logic [2:0] i_cmp_en,
   input wire logic [2:0] i_cmp_lvl,
   input wire logic i_pwm,
   output logic [7:0] o_k_pin,
   output logic [7:0] o_l_pin,
   output logic [7:0] o_l_dir,
   output logic [2:0] o_cmp_en,
   output logic [2:0] o_cmp_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt_q;
   initial begin
      {o_k_pin, o_l_pin, o_l_dir, o_cmp_en, o_cmp_out, cnt_q} = '0;
   end
   always @(posedge i_mclk) begin
      o_k_pin <= i_k_lvl;
      o_l_pin <= i_l_lvl;
      cnt_q <= cnt_q + 3'h1;
      // Software makes compare pins outputs, mux never does
      o_l_dir <= i_l_dir | {2'h0, i_cmp_en, 3'h0};
      o_cmp_en <= i_cmp_en;
      // Free running PWM, three counter bits at periods of 2, 4 and 8 cycles
      o_cmp_out <= i_pwm ? cnt_q : i_cmp_lvl;
   end
endmodule : pkm_far_model

// file: tb/tb.sv
module tb;
   import pkm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic pwm = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0;
   logic [63:0] misc = 64'h0;
   logic [7:0] k_lvl = 8'h00;
   logic [7:0] l_lvl = 8'h00;
   logic [2:0] c_en = 3'h0;
   logic [2:0] c_lvl = 3'h0;
   logic [3:0] csel = 4'h0;
   logic [31:0] rdat;
   logic wreq, irq, t5c, t5p, t4p;
   logic [7:0] k_pin, l_pin, l_dir, kie_en, kie_val, kpo, kpoe, lov_en, lpo, lpoe, pcs, conv;
   logic [7:0] kpup, kpie, lpup, lpie;
   logic [2:0] c_en_m, c_out_m;
   logic [7:0] v, m, x;
   logic [31:0] exp_q[$];
   logic [4:0] ofs[5] = '{PKM_OFS_PC_MASK, PKM_OFS_PC_CTRL, PKM_OFS_IRQ_STATUS,
      PKM_OFS_IRQ_ENABLE, 5'h1c};
   int error_cnt = 0;
   int check_count = 0;

   pkm_far_model i_pkm_far_model (.i_mclk(mclk), .i_k_lvl(k_lvl), .i_l_lvl(l_lvl),
      .i_l_dir(misc[63:56]), .i_cmp_en(c_en), .i_cmp_lvl(c_lvl), .i_pwm(pwm), .o_k_pin(k_pin),
      .o_l_pin(l_pin), .o_l_dir(l_dir), .o_cmp_en(c_en_m), .o_cmp_out(c_out_m));
   pkm_port_mux i_pkm_port_mux (.i_mclk(mclk), .i_sys_rst(rst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_irq(irq), .i_port_k_pin(k_pin),
      .i_port_k_out(misc[7:0]), .i_port_k_dir(misc[15:8]), .i_port_k_pullup(misc[23:16]),
      .i_port_k_in_disable(misc[31:24]), .i_port_l_pin(l_pin), .i_port_l_out(misc[55:48]),
      .i_port_l_dir(l_dir), .i_port_l_pullup(misc[39:32]), .i_port_l_in_disable(misc[47:40]),
      .i_timer5_compare_en(c_en_m), .i_timer5_compare_out(c_out_m),
      .i_converter_channel_sel(csel), .o_k_pullup_override_enable(),
      .o_k_pullup_override_value(), .o_k_direction_override_enable(),
      .o_k_direction_override_value(), .o_k_out_value_override_enable(),
      .o_k_out_value_override_value(), .o_k_input_enable_override_enable(kie_en),
      .o_k_input_enable_override_value(kie_val), .o_k_pad_out(kpo), .o_k_pad_oe(kpoe),
      .o_k_pad_pullup(kpup), .o_k_pad_in_en(kpie), .o_l_pullup_override_enable(),
      .o_l_pullup_override_value(), .o_l_direction_override_enable(),
      .o_l_direction_override_value(), .o_l_out_value_override_enable(lov_en),
      .o_l_out_value_override_value(), .o_l_input_enable_override_enable(),
      .o_l_input_enable_override_value(), .o_l_pad_out(lpo), .o_l_pad_oe(lpoe),
      .o_l_pad_pullup(lpup), .o_l_pad_in_en(lpie), .o_pin_change_source_high_group(pcs),
      .o_converter_channel_15_to_8(conv), .o_timer5_clock_pin(t5c),
      .o_timer5_capture_trigger(t5p), .o_timer4_capture_trigger(t4p));

   initial begin
      forever #25 mclk = ~mclk;
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp(nm, {24'h0, e}, {24'h0, g});
   endtask : cmp8

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick

   // Request held until waitrequest seen low, then one idle edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge mclk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      rd <= 1'b0;
      wr <= 1'b0;
      if (wreq !== 1'b0) begin
         error_cnt++;
         give_verdict();
      end
      @(posedge mclk);
   endtask : bus

   task automatic rdx(input logic [4:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rdx

   // Oldest expectation meets each accepted read
   always @(posedge mclk) begin
      if (rd && wreq === 1'b0) begin
         cmp("readdata", exp_q.pop_front(), rdat);
      end
   end

   initial begin
      void'($urandom(32'h4092));
      tick(8);
      rst <= 1'b0;
      misc <= {$urandom, $urandom};
      foreach (ofs[i]) rdx(ofs[i], 32'h0);
      for (int i = 0; i < 4; i++) begin
         m = (i == 0) ? 8'hff : 8'($urandom);
         bus(1'b1, PKM_OFS_PC_MASK, {24'h0, m});
         bus(1'b1, PKM_OFS_PC_CTRL, 32'h0);
         tick(2);
         cmp8("ie_ovr_off", 8'h00, kie_en);
         bus(1'b1, PKM_OFS_PC_CTRL, 32'h1);
         tick(2);
         cmp8("ie_ovr_on", m, kie_en);
         cmp8("ie_ovr_val", m, kie_val);
      end
      cmp8("k_pad_out", misc[7:0], kpo);
      cmp8("k_pad_oe", misc[15:8], kpoe);
      cmp8("k_pad_pullup", misc[23:16] & ~misc[15:8], kpup);
      cmp8("k_pad_in_en", m | ~misc[31:24], kpie);
      v = 8'($urandom);
      k_lvl <= v;
      tick(6);
      cmp8("pc_src", v, pcs);
      rdx(PKM_OFS_K_SENSE, {24'h0, v});
      for (int s = 0; s < 16; s++) begin
         csel <= 4'(s);
         tick(2);
         cmp("conv_sw", (s >= 8) ? 32'h1 << (s - 8) : 32'h0, {24'h0, conv});
      end
      for (int e = 0; e < 8; e++) begin
         v = 8'($urandom);
         c_en <= 3'(e);
         c_lvl <= v[2:0];
         tick(4);
         x = {2'h0, 3'(e), 3'h0};
         cmp8("l_ovr_en", x, lov_en);
         cmp8("l_pad_out", (x & {2'h0, v[2:0], 3'h0}) | (~x & misc[55:48]), lpo);
         cmp8("l_pad_oe", misc[63:56] | x, lpoe);
         cmp8("l_pad_pullup", misc[39:32] & ~(misc[63:56] | x), lpup);
         cmp8("l_pad_in_en", ~misc[47:40], lpie);
      end
      pwm <= 1'b1;
      tick(16);
      pwm <= 1'b0;
      bus(1'b1, PKM_OFS_IRQ_CLEAR, 32'h3ff);
      bus(1'b1, PKM_OFS_IRQ_ENABLE, 32'h100);
      rdx(PKM_OFS_IRQ_STATUS, 32'h0);
      v = 8'($urandom) | 8'h02;
      l_lvl <= v;
      tick(7);
      cmp8("l_taps", v & 8'h07, {5'h0, t5c, t5p, t4p});
      cmp8("irq_set", 8'h01, {7'h0, irq});
      rdx(PKM_OFS_IRQ_STATUS, {22'h0, v[0], 9'h100});
      rdx(PKM_OFS_L_SENSE, {24'h0, v});
      bus(1'b1, PKM_OFS_IRQ_ENABLE, 32'h0);
      tick(2);
      cmp8("irq_masked", 8'h00, {7'h0, irq});
      bus(1'b1, PKM_OFS_IRQ_CLEAR, 32'h3ff);
      bus(1'b1, PKM_OFS_IRQ_ENABLE, 32'h300);
      tick(2);
      cmp8("irq_clear", 8'h00, {7'h0, irq});
      rdx(PKM_OFS_IRQ_STATUS, 32'h0);
      give_verdict();
   end
endmodule : tb
